/* File: verilog/scd_target.sv */
// target end: collects a cdb, validates it and reports status and message
// assumes bytes arrive one per cycle while busy is low, last byte marked
// How it works
// - only unit zero, inquiry any unit
// - caller zeroes every reserved field in cdb_in
// - control byte reserved and vendor bits checked for zero, except bit 7 on mode select
// - last byte is control: link, flag, vendor
// - linked success gives intermediate status, message
// - link without flag: linked complete message
// - link with flag: linked flagged message
// - initiator keeps flag zero without link
// - mode select control bit 7 sets protect
// - change definition 40 gated, two definitions
// - format 04 gated by protect, like change definition
// - format takes no certification list
// - inquiry 12 needs no spin-up, 36 bytes
// - mode select 15/55, medium, density, length
// - mode pages 01-04, 08, 09, 0a only
// - mode select recovery bits and retry count
// - mode sense page control four meanings
// - block length 512 until mode select
// - read 08/28 needs spin-up, protect ok
// - read buffer 3c needs spin-up, protect ok
`timescale 1ns/1ns
`include "scd_defines.svh"
module scd_target
  import scd_pkg::*;
#(
  parameter int MAX_CDB = 10
)
(
  input wire logic core_clk,
  input wire logic rstn,
  scd_if.target bus,
  input wire logic spun_up,
  input wire logic [7:0] page_code,
  input wire logic [7:0] mode_medium,
  input wire logic [7:0] mode_density,
  input wire logic [15:0] mode_block_len,
  input wire logic [15:0] blocking_factor,
  input wire logic [7:0] mode_recovery,
  input wire logic [7:0] recovery_limit,
  output logic exec_valid,
  output logic [7:0] exec_opcode,
  output logic [15:0] block_len,
  output logic [3:0] recovery_bits,
  output logic [7:0] retry_count,
  output logic [1:0] page_ctl,
  output logic inq_vital_pages,
  output logic [7:0] inq_len
);
  scd_state_e state_q, state_d;
  scd_byte_t cdb_q [MAX_CDB];
  scd_byte_t cdb_d [MAX_CDB];
  logic [3:0] cnt_q, cnt_d;
  logic wp_q, wp_d;
  logic [15:0] blen_q, blen_d;
  logic [3:0] rbits_q, rbits_d;
  logic [7:0] retry_q, retry_d;
  logic [1:0] pctl_q, pctl_d;
  logic vpd_q, vpd_d;
  logic [7:0] inql_q, inql_d;
  logic ev_q, ev_d;
  logic [7:0] eop_q, eop_d;
  logic busy_q, busy_d, done_q, done_d;
  logic [7:0] st_q, st_d, msg_q, msg_d, asc_q, asc_d;
  logic [3:0] key_q, key_d;
  logic [7:0] op, ctl, lunb;
  logic known, need_spin, no_wp, is_msel, is_msns, bad_rsv, page_ok, bl_ok, par_ok;
  always_comb
  begin
    op = cdb_q[0];
    lunb = cdb_q[1];
    ctl = cdb_q[cnt_q - 4'h1];
    is_msel = (op == `SCD_OP_MSEL6) || (op == `SCD_OP_MSEL10);
    is_msns = (op == `SCD_OP_MSNS6) || (op == `SCD_OP_MSNS10);
    known = 1'b1;
    need_spin = 1'b1;
    no_wp = 1'b0;
    unique case (op)
      `SCD_OP_CHG_DEF: no_wp = 1'b1;
      `SCD_OP_FORMAT: no_wp = 1'b1;
      `SCD_OP_INQUIRY: need_spin = 1'b0;
      `SCD_OP_MSEL6, `SCD_OP_MSEL10, `SCD_OP_MSNS6, `SCD_OP_MSNS10: need_spin = 1'b1;
      `SCD_OP_READ6, `SCD_OP_READ10: need_spin = 1'b1;
      `SCD_OP_RDBUF: need_spin = 1'b1;
      default: known = 1'b0;
    endcase
    bad_rsv = ((ctl & (`SCD_CTL_RSV_MASK | (is_msel ? 8'h40 : `SCD_CTL_VU_MASK))) != 8'h00)
      || (!ctl[`SCD_CTL_LINK] && ctl[`SCD_CTL_FLAG]);
    page_ok = 1'b1;
    if (is_msel || is_msns)
      unique case (page_code[5:0])
        6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h09, 6'h0a: page_ok = 1'b1;
        default: page_ok = 1'b0;
      endcase
    bl_ok = (mode_block_len == blocking_factor) || (mode_block_len == blocking_factor << 1)
      || (mode_block_len == blocking_factor << 2) || (mode_block_len == blocking_factor << 3)
      || (mode_block_len == blocking_factor << 4);
    par_ok = page_ok;
    if (is_msel)
      par_ok = page_ok && (mode_medium == 8'h00) && (mode_density == 8'h00) && bl_ok;
    if (op == `SCD_OP_CHG_DEF)
      par_ok = ({1'b0, cdb_q[3][6:0]} == `SCD_DEF_CCS)
        || ({1'b0, cdb_q[3][6:0]} == `SCD_DEF_SCSI2);
    if (op == `SCD_OP_FORMAT)
      par_ok = !(cdb_q[1][4] && cdb_q[1][3]);
  end
  always_comb
  begin
    state_d = state_q;
    cdb_d = cdb_q;
    cnt_d = cnt_q;
    wp_d = wp_q;
    blen_d = blen_q;
    rbits_d = rbits_q;
    retry_d = retry_q;
    pctl_d = pctl_q;
    vpd_d = vpd_q;
    inql_d = inql_q;
    ev_d = 1'b0;
    eop_d = eop_q;
    busy_d = busy_q;
    done_d = 1'b0;
    st_d = st_q;
    msg_d = msg_q;
    key_d = key_q;
    asc_d = asc_q;
    unique case (state_q)
      SCD_IDLE:
      begin
        busy_d = 1'b0;
        cnt_d = 4'h0;
        if (bus.cmd_valid)
        begin
          cdb_d[0] = bus.cmd_byte;
          cnt_d = 4'h1;
          state_d = bus.cmd_last ? SCD_EVAL : SCD_RECV;
          busy_d = bus.cmd_last;
        end
      end
      SCD_RECV:
      begin
        if (bus.cmd_valid && cnt_q < 4'(MAX_CDB))
        begin
          cdb_d[cnt_q] = bus.cmd_byte;
          cnt_d = cnt_q + 4'h1;
          if (bus.cmd_last)
          begin
            state_d = SCD_EVAL;
            busy_d = 1'b1;
          end
        end
      end
      SCD_EVAL:
      begin
        st_d = `SCD_ST_CHECK;
        msg_d = `SCD_MSG_CMD_CPLT;
        key_d = `SCD_KEY_ILLEGAL;
        asc_d = `SCD_ASC_NONE;
        if (!known)
          asc_d = `SCD_ASC_BAD_OPCODE;
        else if ((lunb & `SCD_LUN_MASK) != 8'h00 && op != `SCD_OP_INQUIRY)
          asc_d = `SCD_ASC_BAD_LUN;
        else if (bad_rsv || !par_ok)
          asc_d = `SCD_ASC_BAD_FIELD;
        else if (need_spin && !spun_up)
        begin
          key_d = `SCD_KEY_NOT_READY;
          asc_d = `SCD_ASC_NOT_READY;
        end
        else if (no_wp && wp_q)
        begin
          key_d = `SCD_KEY_PROTECT;
          asc_d = `SCD_ASC_PROTECT;
        end
        else
        begin
          key_d = `SCD_KEY_NONE;
          ev_d = 1'b1;
          eop_d = op;
          st_d = ctl[`SCD_CTL_LINK] ? `SCD_ST_INTERMEDIATE : `SCD_ST_GOOD;
          if (ctl[`SCD_CTL_LINK])
            msg_d = ctl[`SCD_CTL_FLAG] ? `SCD_MSG_LINKED_FLAG : `SCD_MSG_LINKED;
          if (is_msel)
          begin
            wp_d = ctl[`SCD_CTL_WP];
            blen_d = mode_block_len;
            rbits_d = mode_recovery[3:0];
            retry_d = (recovery_limit != 8'h00) ? recovery_limit : {4'h0, mode_recovery[7:4]};
          end
          if (is_msns)
            pctl_d = cdb_q[2][7:6];
          if (op == `SCD_OP_INQUIRY)
          begin
            vpd_d = cdb_q[1][0];
            inql_d = `SCD_INQ_STD_LEN;
          end
        end
        done_d = 1'b1;
        state_d = SCD_DONE;
      end
      SCD_DONE:
      begin
        busy_d = 1'b0;
        state_d = SCD_IDLE;
      end
      default: state_d = SCD_IDLE;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= SCD_IDLE;
      cdb_q <= '{default: 8'h00};
      cnt_q <= 4'h0;
      wp_q <= 1'b0;
      blen_q <= `SCD_DEF_BLOCK_LEN;
      rbits_q <= 4'h0;
      retry_q <= 8'h00;
      pctl_q <= 2'b00;
      vpd_q <= 1'b0;
      inql_q <= 8'h00;
      ev_q <= 1'b0;
      eop_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      st_q <= `SCD_ST_GOOD;
      msg_q <= `SCD_MSG_CMD_CPLT;
      key_q <= `SCD_KEY_NONE;
      asc_q <= `SCD_ASC_NONE;
    end
    else
    begin
      state_q <= state_d;
      cdb_q <= cdb_d;
      cnt_q <= cnt_d;
      wp_q <= wp_d;
      blen_q <= blen_d;
      rbits_q <= rbits_d;
      retry_q <= retry_d;
      pctl_q <= pctl_d;
      vpd_q <= vpd_d;
      inql_q <= inql_d;
      ev_q <= ev_d;
      eop_q <= eop_d;
      busy_q <= busy_d;
      done_q <= done_d;
      st_q <= st_d;
      msg_q <= msg_d;
      key_q <= key_d;
      asc_q <= asc_d;
    end
  end
  assign bus.busy = busy_q;
  assign bus.done = done_q;
  assign bus.status = st_q;
  assign bus.message = msg_q;
  assign bus.sense_key = key_q;
  assign bus.sense_asc = asc_q;
  assign bus.wp_state = wp_q;
  assign exec_valid = ev_q;
  assign exec_opcode = eop_q;
  assign block_len = blen_q;
  assign recovery_bits = rbits_q;
  assign retry_count = retry_q;
  assign page_ctl = pctl_q;
  assign inq_vital_pages = vpd_q;
  assign inq_len = inql_q;
endmodule : scd_target

/* File: verilog/scd_defines.svh */
// constants for the command decoder: opcodes, field positions, status codes
// assumes cdb bytes arrive one per cycle over the scd_if carrier
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH
`define SCD_OP_CHG_DEF 8'h40
`define SCD_OP_FORMAT 8'h04
`define SCD_OP_INQUIRY 8'h12
`define SCD_OP_MSEL6 8'h15
`define SCD_OP_MSEL10 8'h55
`define SCD_OP_MSNS6 8'h1a
`define SCD_OP_MSNS10 8'h5a
`define SCD_OP_READ6 8'h08
`define SCD_OP_READ10 8'h28
`define SCD_OP_RDBUF 8'h3c
`define SCD_CTL_LINK 0
`define SCD_CTL_FLAG 1
`define SCD_CTL_WP 7
`define SCD_CTL_RSV_MASK 8'h3c
`define SCD_CTL_VU_MASK 8'hc0
`define SCD_LUN_MASK 8'he0
`define SCD_ST_GOOD 8'h00
`define SCD_ST_CHECK 8'h02
`define SCD_ST_INTERMEDIATE 8'h10
`define SCD_MSG_CMD_CPLT 8'h00
`define SCD_MSG_LINKED 8'h0a
`define SCD_MSG_LINKED_FLAG 8'h0b
`define SCD_KEY_NONE 4'h0
`define SCD_KEY_NOT_READY 4'h2
`define SCD_KEY_ILLEGAL 4'h5
`define SCD_KEY_PROTECT 4'h7
`define SCD_ASC_NONE 8'h00
`define SCD_ASC_BAD_OPCODE 8'h20
`define SCD_ASC_BAD_FIELD 8'h24
`define SCD_ASC_BAD_LUN 8'h25
`define SCD_ASC_NOT_READY 8'h04
`define SCD_ASC_PROTECT 8'h27
`define SCD_DEF_BLOCK_LEN 16'h0200
`define SCD_INQ_STD_LEN 8'h24
`define SCD_DEF_CCS 8'h00
`define SCD_DEF_SCSI2 8'h03
`endif

/* File: verilog/scd_pkg.sv */
// types shared by both ends of the command decoder
// assumes scd_defines.svh for all numeric constants
package scd_pkg;
  typedef enum logic [3:0] {
    SCD_IDLE = 4'b0001,
    SCD_RECV = 4'b0010,
    SCD_EVAL = 4'b0100,
    SCD_DONE = 4'b1000
  } scd_state_e;
  typedef enum logic [2:0] {
    SCD_H_IDLE = 3'b001,
    SCD_H_SEND = 3'b010,
    SCD_H_WAIT = 3'b100
  } scd_hstate_e;
  typedef logic [7:0] scd_byte_t;
endpackage : scd_pkg

/* File: verilog/scd_if.sv */
// carrier between initiator end and target decoder end
// assumes one shared clock; bytes move on cmd_valid, results on done
`timescale 1ns/1ns
interface scd_if;
  logic [7:0] cmd_byte;
  logic cmd_valid;
  logic cmd_last;
  logic busy;
  logic done;
  logic [7:0] status;
  logic [7:0] message;
  logic [3:0] sense_key;
  logic [7:0] sense_asc;
  logic wp_state;
  modport target (input cmd_byte, input cmd_valid, input cmd_last, output busy,
    output done, output status, output message, output sense_key, output sense_asc,
    output wp_state);
  modport initiator (output cmd_byte, output cmd_valid, output cmd_last, input busy,
    input done, input status, input message, input sense_key, input sense_asc,
    input wp_state);
endinterface : scd_if

/* File: verilog/scd_initiator.sv */
// initiator end: sends a stored cdb byte by byte and captures the answer
// assumes the target raises done one cycle after taking the last byte
`timescale 1ns/1ns
`include "scd_defines.svh"
module scd_initiator
  import scd_pkg::*;
#(
  parameter int MAX_CDB = 10
)
(
  input wire logic core_clk,
  input wire logic rstn,
  scd_if.initiator bus,
  input wire logic start,
  input wire logic [3:0] cdb_len,
  input wire logic [MAX_CDB*8-1:0] cdb_in,
  output logic ready,
  output logic result_valid,
  output logic [7:0] result_status,
  output logic [7:0] result_message,
  output logic [11:0] result_sense
);
  scd_hstate_e state_q, state_d;
  logic [MAX_CDB*8-1:0] sh_q, sh_d;
  logic [3:0] left_q, left_d;
  logic rv_q, rv_d, rdy_q, rdy_d;
  logic [7:0] rs_q, rs_d, rm_q, rm_d;
  logic [11:0] se_q, se_d;
  logic [7:0] ctl_fix;
  always_comb
  begin
    state_d = state_q;
    sh_d = sh_q;
    left_d = left_q;
    rv_d = 1'b0;
    rdy_d = rdy_q;
    rs_d = rs_q;
    rm_d = rm_q;
    se_d = se_q;
    ctl_fix = sh_q[7:0];
    if (left_q == 4'h1 && !ctl_fix[`SCD_CTL_LINK])
      ctl_fix[`SCD_CTL_FLAG] = 1'b0;
    unique case (state_q)
      SCD_H_IDLE:
      begin
        rdy_d = 1'b1;
        if (start && cdb_len != 4'h0)
        begin
          sh_d = cdb_in;
          left_d = cdb_len;
          rdy_d = 1'b0;
          state_d = SCD_H_SEND;
        end
      end
      SCD_H_SEND:
      begin
        sh_d = sh_q >> 8;
        left_d = left_q - 4'h1;
        if (left_q == 4'h1)
          state_d = SCD_H_WAIT;
      end
      SCD_H_WAIT:
      begin
        if (bus.done)
        begin
          rv_d = 1'b1;
          rs_d = bus.status;
          rm_d = bus.message;
          se_d = {bus.sense_key, bus.sense_asc};
          rdy_d = 1'b1;
          state_d = SCD_H_IDLE;
        end
      end
      default: state_d = SCD_H_IDLE;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= SCD_H_IDLE;
      sh_q <= '0;
      left_q <= 4'h0;
      rv_q <= 1'b0;
      rdy_q <= 1'b0;
      rs_q <= 8'h00;
      rm_q <= 8'h00;
      se_q <= 12'h000;
    end
    else
    begin
      state_q <= state_d;
      sh_q <= sh_d;
      left_q <= left_d;
      rv_q <= rv_d;
      rdy_q <= rdy_d;
      rs_q <= rs_d;
      rm_q <= rm_d;
      se_q <= se_d;
    end
  end
  // reserved fields are the caller's to zero in cdb_in
  assign bus.cmd_valid = (state_q == SCD_H_SEND);
  assign bus.cmd_last = (state_q == SCD_H_SEND) && (left_q == 4'h1);
  assign bus.cmd_byte = (state_q == SCD_H_SEND) ? ctl_fix : 8'h00;
  assign ready = rdy_q;
  assign result_valid = rv_q;
  assign result_status = rs_q;
  assign result_message = rm_q;
  assign result_sense = se_q;
endmodule : scd_initiator

/* File: bench/scd_monitor.sv */
// checker on the scd_if carrier: answer timing, status, message, sense
// assumes instantiation beside the carrier, one clock, sync active-low reset
`timescale 1ns/1ns
`include "scd_defines.svh"
module scd_monitor
  import scd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic cmd_last,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] status,
  input wire logic [7:0] message,
  input wire logic [3:0] sense_key,
  input wire logic [7:0] sense_asc,
  input wire logic wp_state
);
  logic [3:0] idx_q;
  logic [7:0] op_q;
  logic [7:0] lun_q;
  logic [7:0] ctl_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // capture opcode, unit byte and control byte of each cdb
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      idx_q <= 4'h0;
      op_q <= 8'h00;
      lun_q <= 8'h00;
      ctl_q <= 8'h00;
    end
    else if (cmd_valid && !busy)
    begin
      idx_q <= cmd_last ? 4'h0 : idx_q + 4'h1;
      if (idx_q == 4'h0)
        op_q <= cmd_byte;
      if (idx_q == 4'h1)
        lun_q <= cmd_byte;
      if (cmd_last)
        ctl_q <= cmd_byte;
    end
  end
  property p_answer;
    cmd_valid && cmd_last |-> ##1 busy ##1 done;
  endproperty
  property p_done_pulse;
    done |=> !done && $stable(status) && $stable(sense_asc);
  endproperty
  property p_good_clean;
    done && status == `SCD_ST_GOOD |-> sense_key == `SCD_KEY_NONE
      && message == `SCD_MSG_CMD_CPLT && !ctl_q[0];
  endproperty
  property p_check_sense;
    done && status == `SCD_ST_CHECK |-> sense_key != `SCD_KEY_NONE
      && message == `SCD_MSG_CMD_CPLT;
  endproperty
  property p_linked;
    done && ctl_q[0] && status != `SCD_ST_CHECK |-> status == `SCD_ST_INTERMEDIATE;
  endproperty
  property p_msg_sel;
    done && status == `SCD_ST_INTERMEDIATE
      |-> message == (ctl_q[1] ? `SCD_MSG_LINKED_FLAG : `SCD_MSG_LINKED);
  endproperty
  property p_bad_op;
    done && op_q == 8'hff |-> status == `SCD_ST_CHECK
      && sense_key == `SCD_KEY_ILLEGAL && sense_asc == `SCD_ASC_BAD_OPCODE;
  endproperty
  property p_lun;
    done && lun_q[7:5] != 3'h0 && op_q inside {`SCD_OP_READ6, `SCD_OP_READ10}
      |-> sense_asc == `SCD_ASC_BAD_LUN;
  endproperty
  property p_inq;
    done && op_q == `SCD_OP_INQUIRY && ctl_q == 8'h00 |-> status == `SCD_ST_GOOD;
  endproperty
  property p_wp;
    done && op_q == `SCD_OP_MSEL6 && status == `SCD_ST_GOOD |-> ##[0:1] wp_state == ctl_q[7];
  endproperty
  a_answer: assert property (p_answer) else $error("no done two cycles after last byte");
  a_done_pulse: assert property (p_done_pulse) else $error("done not a held pulse");
  a_good_clean: assert property (p_good_clean) else $error("good with sense or link");
  a_check_sense: assert property (p_check_sense) else $error("check without sense");
  a_linked: assert property (p_linked) else $error("linked not intermediate");
  a_msg_sel: assert property (p_msg_sel) else $error("linked message wrong");
  a_bad_op: assert property (p_bad_op) else $error("unknown opcode not illegal");
  a_lun: assert property (p_lun) else $error("nonzero unit accepted");
  a_inq: assert property (p_inq) else $error("inquiry refused");
  a_wp: assert property (p_wp) else $error("protect not from control bit 7");
  c_flag: cover property (done && message == `SCD_MSG_LINKED_FLAG);
  c_check: cover property (done && status == `SCD_ST_CHECK);
  c_wp: cover property (done && wp_state);
endmodule : scd_monitor

/* File: bench/tb_scd_command_decoder.sv */
// self-checking bench: initiator and target ends joined by scd_if
// assumes 10 MHz core_clk and synchronous active-low rstn
`timescale 1ns/1ns
`include "scd_defines.svh"
module tb_scd_command_decoder;
  import scd_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic [3:0] cdb_len = 4'h6;
  logic [79:0] cdb_in = '0;
  logic spun_up = 1'b0;
  logic [7:0] page_code = 8'h01;
  logic [15:0] mode_block_len = 16'h0200;
  logic [15:0] blocking_factor = 16'h0200;
  logic [7:0] mode_recovery = 8'h00;
  logic [7:0] mode_medium = 8'h00;
  logic [7:0] mode_density = 8'h00;
  logic [7:0] recovery_limit = 8'h00;
  logic [15:0] cdb_mid = 16'h0000;
  logic exec_valid;
  logic [7:0] exec_opcode;
  logic [3:0] recovery_bits;
  logic [7:0] retry_count;
  logic [1:0] page_ctl;
  logic inq_vital_pages;
  logic [7:0] inq_len;
  int n_exec = 0;
  logic ready;
  logic result_valid;
  logic [7:0] result_status;
  logic [7:0] result_message;
  logic [11:0] result_sense;
  logic [15:0] block_len;
  int miscompares = 0;
  int n_compared = 0;
  scd_if sif();
  always #50 core_clk = ~core_clk;
  // count accepted-command pulses away from the launching edge
  always @(negedge core_clk)
    if (exec_valid === 1'b1)
      n_exec++;
  scd_target #(.MAX_CDB(10)) u_scd_target (.core_clk(core_clk), .rstn(rstn),
    .bus(sif.target), .spun_up(spun_up), .page_code(page_code), .mode_medium(mode_medium),
    .mode_density(mode_density), .mode_block_len(mode_block_len),
    .blocking_factor(blocking_factor), .mode_recovery(mode_recovery),
    .recovery_limit(recovery_limit), .exec_valid(exec_valid), .exec_opcode(exec_opcode),
    .block_len(block_len), .recovery_bits(recovery_bits), .retry_count(retry_count),
    .page_ctl(page_ctl), .inq_vital_pages(inq_vital_pages), .inq_len(inq_len));
  scd_initiator #(.MAX_CDB(10)) u_scd_initiator (.core_clk(core_clk), .rstn(rstn),
    .bus(sif.initiator), .start(start), .cdb_len(cdb_len), .cdb_in(cdb_in), .ready(ready),
    .result_valid(result_valid), .result_status(result_status),
    .result_message(result_message), .result_sense(result_sense));
  scd_monitor u_scd_monitor (.core_clk(core_clk), .rstn(rstn), .cmd_byte(sif.cmd_byte),
    .cmd_valid(sif.cmd_valid), .cmd_last(sif.cmd_last), .busy(sif.busy), .done(sif.done),
    .status(sif.status), .message(sif.message), .sense_key(sif.sense_key),
    .sense_asc(sif.sense_asc), .wp_state(sif.wp_state));
  task automatic complete_run();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // send one cdb and compare status, message and {key,asc}
  task automatic cmd(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] ctl,
    input logic [7:0] st, input logic [7:0] msg, input logic [11:0] sns);
    int n;
    int n_ex;
    logic [3:0] len;
    n = 0;
    n_ex = n_exec;
    len = (op >= 8'h20) ? 4'ha : 4'h6;
    while (ready !== 1'b1 && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    cdb_in = '0;
    cdb_in[7:0] = op;
    cdb_in[15:8] = b1;
    cdb_in[31:16] = cdb_mid;
    cdb_in[len*8-8 +: 8] = ctl;
    cdb_len = len;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    while (result_valid !== 1'b1 && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 60)
    begin
      miscompares++;
      complete_run();
    end
    check("status", {8'h00, result_status}, {8'h00, st});
    check("message", {8'h00, result_message}, {8'h00, msg});
    check("sense", {4'h0, result_sense}, {4'h0, sns});
    check("exec_valid", 16'(n_exec - n_ex), {15'h0, st != `SCD_ST_CHECK});
    if (st != `SCD_ST_CHECK)
      check("exec_opcode", {8'h00, exec_opcode}, {8'h00, op});
  endtask : cmd
  task automatic t_reset();
    check("block_len", block_len, 16'h0200);
    check("wp_state", {15'h0, sif.wp_state}, 16'h0000);
  endtask : t_reset
  task automatic t_spinup();
    cmd(`SCD_OP_INQUIRY, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    check("inq_len", {8'h00, inq_len}, {8'h00, `SCD_INQ_STD_LEN});
    check("inq_vital_pages", {15'h0, inq_vital_pages}, 16'h0000);
    cmd(`SCD_OP_READ6, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h204);
    cmd(`SCD_OP_READ10, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h204);
    cmd(`SCD_OP_RDBUF, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h204);
    cmd(`SCD_OP_FORMAT, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h204);
    cmd(`SCD_OP_CHG_DEF, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h204);
    spun_up = 1'b1;
    cmd(`SCD_OP_READ10, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    cmd(`SCD_OP_RDBUF, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    cmd(`SCD_OP_FORMAT, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    cmd(`SCD_OP_CHG_DEF, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    cmd(`SCD_OP_FORMAT, 8'h18, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h524);
    cdb_mid = 16'h0500;
    cmd(`SCD_OP_CHG_DEF, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h524);
    cdb_mid = 16'h0300;
    cmd(`SCD_OP_CHG_DEF, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    cdb_mid = 16'h0000;
  endtask : t_spinup
  task automatic t_fields();
    cmd(`SCD_OP_READ6, 8'h20, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h525);
    cmd(`SCD_OP_INQUIRY, 8'he0, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    cmd(`SCD_OP_INQUIRY, 8'h01, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    check("inq_vital_pages", {15'h0, inq_vital_pages}, 16'h0001);
    cmd(8'hff, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h520);
    cmd(`SCD_OP_READ6, 8'h00, 8'h04, `SCD_ST_CHECK, 8'h00, 12'h524);
    cmd(`SCD_OP_READ6, 8'h00, 8'h40, `SCD_ST_CHECK, 8'h00, 12'h524);
  endtask : t_fields
  task automatic t_link();
    cmd(`SCD_OP_READ6, 8'h00, 8'h01, `SCD_ST_INTERMEDIATE, 8'h0a, 12'h000);
    cmd(`SCD_OP_READ6, 8'h00, 8'h03, `SCD_ST_INTERMEDIATE, 8'h0b, 12'h000);
    cmd(`SCD_OP_INQUIRY, 8'h00, 8'h01, `SCD_ST_INTERMEDIATE, 8'h0a, 12'h000);
    cmd(`SCD_OP_READ6, 8'h00, 8'h02, `SCD_ST_GOOD, 8'h00, 12'h000);
  endtask : t_link
  task automatic t_mode();
    mode_block_len = 16'h0400;
    cmd(`SCD_OP_MSEL6, 8'h00, 8'h80, `SCD_ST_GOOD, 8'h00, 12'h000);
    check("wp_state", {15'h0, sif.wp_state}, 16'h0001);
    check("block_len", block_len, 16'h0400);
    cmd(`SCD_OP_FORMAT, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h727);
    cmd(`SCD_OP_CHG_DEF, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h727);
    cmd(`SCD_OP_READ6, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    cdb_mid = 16'h0080;
    cmd(`SCD_OP_MSNS6, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    cdb_mid = 16'h0000;
    check("page_ctl", {14'h0, page_ctl}, 16'h0002);
    page_code = 8'h05;
    cmd(`SCD_OP_MSEL6, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h524);
    page_code = 8'h0a;
    mode_block_len = 16'h0600;
    cmd(`SCD_OP_MSEL10, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h524);
    mode_block_len = 16'h0200;
    mode_recovery = 8'h5a;
    cmd(`SCD_OP_MSEL6, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    check("wp_state", {15'h0, sif.wp_state}, 16'h0000);
    check("block_len", block_len, 16'h0200);
    check("recovery_bits", {12'h000, recovery_bits}, 16'h000a);
    check("retry_count", {8'h00, retry_count}, 16'h0005);
    recovery_limit = 8'h09;
    cmd(`SCD_OP_MSEL6, 8'h00, 8'h00, `SCD_ST_GOOD, 8'h00, 12'h000);
    check("retry_count", {8'h00, retry_count}, 16'h0009);
    recovery_limit = 8'h00;
    mode_medium = 8'h01;
    cmd(`SCD_OP_MSEL6, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h524);
    mode_medium = 8'h00;
    mode_density = 8'h01;
    cmd(`SCD_OP_MSEL6, 8'h00, 8'h00, `SCD_ST_CHECK, 8'h00, 12'h524);
    mode_density = 8'h00;
  endtask : t_mode
  initial
  begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_spinup();
    t_fields();
    t_link();
    t_mode();
    complete_run();
  end
endmodule : tb_scd_command_decoder
